// ===== inc/fsrr_consts.vh
// Constants for the flash status register read block.
`ifndef FSRR_CONSTS_VH
`define FSRR_CONSTS_VH
`define FSRR_CMD_READ_STATUS 8'h05
`define FSRR_BIT_LOCKED 7
`define FSRR_BIT_RESERVED 6
`define FSRR_BIT_ERROR 5
`define FSRR_BIT_PIN 4
`define FSRR_BIT_SWP_HI 3
`define FSRR_BIT_SWP_LO 2
`define FSRR_BIT_WEL 1
`define FSRR_BIT_BUSY 0
`define FSRR_SWP_NONE 2'h0
`define FSRR_SWP_SOME 2'h1
`define FSRR_SWP_ALL 2'h3
`define FSRR_RST_LOCKED 1'h0
`define FSRR_LAST_BIT 3'h7
`endif

// ===== design/fsrr_top.v
// Status register read logic of a serial flash, SPI mode 0/3 slave side.
`timescale 1ns/1ps
`default_nettype none
`include "fsrr_consts.vh"
module fsrr_top
(
   // Clock and reset.
   input wire clock_i,
   input wire rst_i,
   // Serial bus pins.
   input wire spi_clk_i,
   input wire spi_cs_n_i,
   input wire spi_mosi_i,
   output reg spi_miso_o,
   output reg spi_miso_oe_o,
   // Internal status sources, same clock domain.
   input wire lock_wr_i,
   input wire lock_val_i,
   input wire erase_program_error_i,
   input wire write_protect_n_i,
   input wire [1:0] software_protection_summary_i,
   input wire write_enable_latch_i,
   input wire ready_busy_flag_i,
   input wire [7:0] status_byte_two_i,
   // Status view.
   output reg protection_regs_locked_o,
   output reg read_active_o
);

// ===========================================================
// Pin synchronisers
// Every pin passes two flops before any logic reads it. Only the second
// stage is read, which keeps a metastable first stage out of the state
// machine at the cost of two clocks of lag on each bus edge.
reg [1:0] clk_s_q;
reg [1:0] cs_s_q;
reg [1:0] mosi_s_q;
reg [1:0] wp_s_q;
reg clk_prev_q;
wire sclk;
wire cs_n;
wire rise;
wire fall;

assign sclk = clk_s_q[1];
assign cs_n = cs_s_q[1];
assign rise = sclk & ~clk_prev_q;
assign fall = ~sclk & clk_prev_q;

always @(posedge clock_i)
begin
   if (rst_i)
   begin
      clk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      mosi_s_q <= 2'h0;
      wp_s_q <= 2'h3;
      clk_prev_q <= 1'h0;
   end
   else
   begin
      clk_s_q <= {clk_s_q[0], spi_clk_i};
      cs_s_q <= {cs_s_q[0], spi_cs_n_i};
      mosi_s_q <= {mosi_s_q[0], spi_mosi_i};
      wp_s_q <= {wp_s_q[0], write_protect_n_i};
      clk_prev_q <= sclk;
   end
end

// ===========================================================
// Status byte assembly
// Byte one is rebuilt from live inputs on every clock, so each load into
// the shifter takes a fresh snapshot rather than a stale copy.
function [7:0] status_one;
   input locked;
   input err;
   input wp_n;
   input [1:0] software_protection_summary;
   input write_enable_latch;
   input busy;
   begin
      status_one = 8'h00;
      status_one[`FSRR_BIT_LOCKED] = locked;
      status_one[`FSRR_BIT_RESERVED] = 1'b0;
      status_one[`FSRR_BIT_ERROR] = err;
      status_one[`FSRR_BIT_PIN] = wp_n;
      // Summary passes 00, 01 or 11 from the sector logic.
      status_one[`FSRR_BIT_SWP_HI:`FSRR_BIT_SWP_LO] = software_protection_summary;
      status_one[`FSRR_BIT_WEL] = write_enable_latch;
      status_one[`FSRR_BIT_BUSY] = busy;
   end
endfunction

// ===========================================================
// Command and shift states
localparam ST_IDLE = 4'h1;
localparam ST_CMD = 4'h2;
localparam ST_SEND = 4'h4;
// Refused command: the slave stays silent until chip select rises.
localparam ST_WAIT = 4'h8;

reg [3:0] state_q;
reg [2:0] bit_cnt_q;
reg [7:0] cmd_q;
reg [7:0] shift_q;
reg byte_sel_q;
wire [7:0] byte_one;
wire [7:0] byte_two;
wire [7:0] cmd_next;

assign byte_one = status_one(protection_regs_locked_o,
   erase_program_error_i, wp_s_q[1], software_protection_summary_i,
   write_enable_latch_i, ready_busy_flag_i);
assign byte_two = {status_byte_two_i[7:1], ready_busy_flag_i};
assign cmd_next = {cmd_q[6:0], mosi_s_q[1]};

// The lock flag is the only bit of byte one that can be written.
always @(posedge clock_i)
begin
   if (rst_i)
      protection_regs_locked_o <= `FSRR_RST_LOCKED;
   else if (lock_wr_i)
      protection_regs_locked_o <= lock_val_i;
end

// Shifting happens on synchronised edges, so the bus clock must stay
// well below a quarter of clock_i.
always @(posedge clock_i)
begin
   if (rst_i)
   begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      cmd_q <= 8'h00;
      shift_q <= 8'h00;
      byte_sel_q <= 1'b0;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      read_active_o <= 1'b0;
   end
   else if (cs_n)
   begin
      // Release ends the read at any bit position.
      // A partial byte is dropped; the next frame starts with byte one.
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      spi_miso_oe_o <= 1'b0;
      read_active_o <= 1'b0;
   end
   else
   begin
      case (state_q)
         ST_IDLE:
         begin
            state_q <= ST_CMD;
            bit_cnt_q <= 3'h0;
         end
         ST_CMD:
         begin
            // An idle-high clock gives a fall before the first rise; the
            // command phase looks only at rises, so that fall is harmless.
            if (rise)
            begin
               cmd_q <= cmd_next;
               bit_cnt_q <= bit_cnt_q + 3'h1;
               // Busy does not gate acceptance.
               if (bit_cnt_q == `FSRR_LAST_BIT)
               begin
                  if (cmd_next == `FSRR_CMD_READ_STATUS)
                  begin
                     state_q <= ST_SEND;
                     shift_q <= byte_one;
                     byte_sel_q <= 1'b1;
                     read_active_o <= 1'b1;
                  end
                  else
                     state_q <= ST_WAIT;
               end
            end
         end
         ST_SEND:
         begin
            if (fall)
            begin
               // Drive on the fall so the host samples a settled bit.
               spi_miso_o <= shift_q[7];
               spi_miso_oe_o <= 1'b1;
               bit_cnt_q <= bit_cnt_q + 3'h1;
               if (bit_cnt_q == `FSRR_LAST_BIT)
               begin
                  // Fresh sample of the next byte, alternating.
                  shift_q <= byte_sel_q ? byte_two : byte_one;
                  byte_sel_q <= ~byte_sel_q;
               end
               else
                  shift_q <= {shift_q[6:0], 1'b0};
            end
         end
         ST_WAIT:
            state_q <= ST_WAIT;
         default:
            state_q <= ST_IDLE;
      endcase
   end
end

endmodule // fsrr_top
`default_nettype wire

// ===== tb/fsrr_assertions.sv
// Port assertions of the status read block.
`timescale 1ns/1ps
`default_nettype none
module fsrr_chk
(
   input wire clock_i, rst_i, spi_clk_i, spi_cs_n_i, spi_miso_o,
   input wire spi_miso_oe_o, lock_wr_i, lock_val_i,
   input wire protection_regs_locked_o, read_active_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence s_hi; (spi_miso_oe_o && spi_clk_i) [*8]; endsequence
   property p_end; $rose(spi_cs_n_i) |-> ##[1:6] !read_active_o; endproperty
   a_end: assert property (p_end) else $error("read kept");
   property p_off; spi_cs_n_i [*6] |-> !spi_miso_oe_o; endproperty
   a_off: assert property (p_off) else $error("oe idle");
   property p_sel; spi_miso_oe_o |-> !$past(spi_cs_n_i, 6); endproperty
   a_sel: assert property (p_sel) else $error("oe early");
   property p_go; $rose(read_active_o) |-> ##[1:30] spi_miso_oe_o; endproperty
   a_go: assert property (p_go) else $error("no data");
   property p_rpt; read_active_o && !spi_cs_n_i |=> read_active_o;
   endproperty
   a_rpt: assert property (p_rpt) else $error("read lost");
   property p_bit; s_hi |-> $stable(spi_miso_o); endproperty
   a_bit: assert property (p_bit) else $error("bit moved");
   property p_lk; lock_wr_i |=> protection_regs_locked_o == $past(lock_val_i);
   endproperty
   a_lk: assert property (p_lk) else $error("lock write");
   property p_kp; !lock_wr_i |=> $stable(protection_regs_locked_o);
   endproperty
   a_kp: assert property (p_kp) else $error("lock drift");
endmodule // fsrr_chk
bind fsrr_top fsrr_chk fsrr_chk_i (.*);
`default_nettype wire

// ===== tb/fsrr_host.sv
// Host controller model that runs status read frames.
`timescale 1ns/1ps
`default_nettype none
`include "fsrr_consts.vh"
module fsrr_host
(
   input wire logic clock_i, so_i, so_oe_i,
   output logic sclk_o = 1'h0, cs_n_o = 1'h1, mosi_o = 1'h1,
   output logic [31:0] rx_o = 32'h0
);
   // A floating line must not read as a clean level, so it reads inverted.
   wire logic so_w = so_oe_i ? so_i : ~rx_o[0];
   // Trailing bits repeat the status opcode, so a slave that wrongly
   // rearms after a refused opcode would answer and be caught.
   localparam logic [7:0] FOLLOW_CMD = `FSRR_CMD_READ_STATUS;
   task automatic frame(input logic [7:0] cmd, input int nb);
      @(posedge clock_i);
      cs_n_o <= 1'h0;
      for (int i = 0; i < nb + 8; i++)
      begin
         mosi_o <= i < 8 ? cmd[7 - i] : FOLLOW_CMD[7 - i % 8];
         repeat (12) @(posedge clock_i);
         sclk_o <= 1'h1;
         rx_o <= {rx_o[30:0], so_w};
         repeat (13) @(posedge clock_i);
         sclk_o <= 1'h0;
      end
      repeat (12) @(posedge clock_i);
      cs_n_o <= 1'h1;
      repeat (12) @(posedge clock_i);
   endtask
endmodule // fsrr_host
`default_nettype wire

// ===== tb/tb_fsrr_top.sv
// Self-checking bench of the status read block.
`timescale 1ns/1ps
`default_nettype none
module tb_fsrr_top;
   logic clock_i = 1'h0, rst_i = 1'h1, lock_wr_i = 1'h0, lock_val = 1'h1;
   logic [13:0] st_q = 14'h0;
   wire logic spi_clk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
   wire logic lk, ra;
   wire logic [31:0] rx;
   int n_mismatch = 0, tests_run = 0;
   int n_oe = 0, oe_mark = 0;
   // Status levels, byte two, then bytes one and two as read back.
   logic [29:0] rows [3] = '{{6'h1C, 8'hA5, 16'h1CA4},
      {6'h27, 8'h5A, 16'h275B}, {6'h13, 8'hFF, 16'h13FF}};
   fsrr_top fsrr_top_i (.clock_i, .rst_i, .spi_clk_i, .spi_cs_n_i,
      .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o, .lock_wr_i,
      .lock_val_i(lock_val),
      .erase_program_error_i(st_q[13]), .write_protect_n_i(st_q[12]),
      .software_protection_summary_i(st_q[11:10]),
      .write_enable_latch_i(st_q[9]), .ready_busy_flag_i(st_q[8]),
      .status_byte_two_i(st_q[7:0]), .protection_regs_locked_o(lk),
      .read_active_o(ra));
   fsrr_host fsrr_host_i (.clock_i, .so_i(spi_miso_o),
      .so_oe_i(spi_miso_oe_o), .sclk_o(spi_clk_i), .cs_n_o(spi_cs_n_i),
      .mosi_o(spi_mosi_i), .rx_o(rx));
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial forever #2.5 clock_i = ~clock_i;
   // Counts enabled-output cycles so a refused frame can be shown silent.
   always @(posedge clock_i)
      if (spi_miso_oe_o)
         n_oe <= n_oe + 1;
   initial
   begin
      #60000 n_mismatch++;
      conclude;
   end
   initial
   begin
      repeat (3) @(posedge clock_i);
      rst_i <= 1'h0;
      fsrr_host_i.frame(8'h05, 5);
      chk("idle", 32'h0, {spi_miso_oe_o, lk, ra});
      foreach (rows[i])
      begin
         st_q <= rows[i][29:16];
         fsrr_host_i.frame(8'h05, 32);
         chk("status", {2{rows[i][15:0]}}, rx);
      end
      lock_wr_i <= 1'h1;
      st_q <= 14'h1CA5;
      @(posedge clock_i);
      lock_wr_i <= 1'h0;
      // Busy rises during byte two, so only bytes three and four see it.
      fork
         fsrr_host_i.frame(8'h05, 32);
         #2500 st_q[8] <= 1'h1;
      join
      chk("lock", 32'h1, {31'h0, lk});
      chk("fresh", 32'h9CA49DA5, rx);
      // Clearing the lock flag must work as well as setting it.
      lock_val <= 1'h0;
      lock_wr_i <= 1'h1;
      @(posedge clock_i);
      lock_wr_i <= 1'h0;
      lock_val <= 1'h1;
      repeat (2) @(posedge clock_i);
      chk("unlock", 32'h0, {31'h0, lk});
      // Reset in mid-read: output floats, lock returns to its default.
      lock_wr_i <= 1'h1;
      @(posedge clock_i);
      lock_wr_i <= 1'h0;
      fork
         fsrr_host_i.frame(8'h05, 16);
         begin
            repeat (300) @(posedge clock_i);
            rst_i <= 1'h1;
            repeat (3) @(posedge clock_i);
            chk("reset", 32'h0, {spi_miso_oe_o, lk, ra});
            rst_i <= 1'h0;
         end
      join
      // A refused opcode followed by the status opcode stays silent.
      oe_mark = n_oe;
      fsrr_host_i.frame(8'h9F, 16);
      chk("refused", oe_mark, n_oe);
      conclude;
   end
endmodule // tb_fsrr_top
`default_nettype wire
